// *** hw/cascade_serial_master.sv ***
// bus controller end: apb registers drive two-wire transfers
`timescale 1ns/1ps
`include "csr_defs.svh"
module cascade_serial_master
	import csr_pkg::*;
#(
	parameter int HALF_CYC = `SCL_HALF_CYC
)(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             busy,
	link_if.ctrl             link
);
	logic [31:0] cmd_reg, wdata_reg, rdata_reg, prdata_reg;
	logic        pready_reg, pslverr_reg, busy_reg, nack_reg, done_reg;
	logic [15:0] div_reg;
	logic [1:0]  sda_sync_reg;
	mst_state_t  mst_reg, mst_next;
	byte_kind_t  kind_reg, kind_next;
	logic [4:0]  ph_reg, ph_next;
	logic [1:0]  idx_reg, idx_next;
	logic [7:0]  sh_reg, sh_next;
	logic        rs_reg, rs_next, nack_set, fin, recv_end;
	logic        scl_low_reg, sda_low_reg, zero_reg, scl_low_w, sda_low_w;

	// apb decode: one setup cycle, then a zero-wait access
	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready_reg;
	wire sel_cmd  = paddr == `APB_CMD_OFS;
	wire sel_wd   = paddr == `APB_WDATA_OFS;
	wire sel_rd   = paddr == `APB_RDATA_OFS;
	wire sel_st   = paddr == `APB_STATUS_OFS;
	wire mapped   = sel_cmd | sel_wd | sel_rd | sel_st;
	wire cmd_wr   = access & pwrite & sel_cmd & ~busy_reg;
	wire launch   = cmd_wr & pwdata[`CMD_GO_BIT];
	wire st_wr    = access & pwrite & sel_st;
	wire [31:0] status_w = {29'h0, done_reg, nack_reg, busy_reg};
	wire [31:0] rd_mux = sel_cmd ? cmd_reg : sel_wd ? wdata_reg :
		sel_rd ? rdata_reg : sel_st ? status_w : 32'h0;

	// command fields
	wire       cmd_read = cmd_reg[`CMD_READ_BIT];
	wire       cmd_cur  = cmd_reg[`CMD_CUR_BIT];
	wire [1:0] cmd_len  = cmd_reg[`CMD_LEN_LSB +: 2];
	wire [6:0] cmd_dev  = cmd_reg[`CMD_DEV_LSB +: 7];
	wire [7:0] cmd_ra   = cmd_reg[`CMD_REG_LSB +: 8];

	// half-period tick of the generated serial clock
	wire tick = busy_reg & (div_reg == 16'(HALF_CYC - 1));
	wire sda_s = sda_sync_reg[1];
	wire [3:0] bit_w = ph_reg[4:1];
	wire [7:0] tx_byte = (kind_reg == K_SLAVE_W) ? {cmd_dev, 1'b0} :
		(kind_reg == K_SLAVE_R) ? {cmd_dev, 1'b1} :
		(kind_reg == K_REG) ? cmd_ra : wdata_reg[{idx_reg, 3'b000} +: 8];
	wire last = idx_reg == cmd_len;

	// sequencer: master starts every transfer and clocks it
	always_comb begin
		mst_next = mst_reg;
		ph_next  = ph_reg;
		kind_next = kind_reg;
		idx_next = idx_reg;
		rs_next  = rs_reg;
		sh_next  = sh_reg;
		nack_set = 1'b0;
		fin      = 1'b0;
		recv_end = 1'b0;
		if (launch) begin
			mst_next = M_START;
			ph_next  = 5'd0;
			rs_next  = 1'b0;
			idx_next = 2'd0;
		end else if (tick) begin
			ph_next = ph_reg + 5'd1;
			case (mst_reg)
				M_START: if (ph_reg == 5'd2) begin
					mst_next  = M_SEND;
					ph_next   = 5'd0;
					kind_next = (cmd_cur | rs_reg) ? K_SLAVE_R : K_SLAVE_W;
				end
				M_SEND: if (ph_reg == 5'd17) begin
					ph_next = 5'd0;
					if (sda_s) begin
						nack_set = 1'b1;
						mst_next = M_STOP;
					end else begin
						case (kind_reg)
							K_SLAVE_W: kind_next = K_REG;
							K_REG: if (cmd_read) begin
								mst_next = M_START; // repeated start
								rs_next  = 1'b1;
							end else begin
								kind_next = K_DATA;
							end
							K_DATA: if (last) begin
								mst_next = M_STOP;
							end else begin
								idx_next = idx_reg + 2'd1;
							end
							default: mst_next = M_RECV;
						endcase
					end
				end
				M_RECV: begin
					if (ph_reg[0] && bit_w < 4'd8) begin
						sh_next = {sh_reg[6:0], sda_s}; // msb first
					end
					if (ph_reg == 5'd17) begin
						ph_next  = 5'd0;
						recv_end = 1'b1;
						if (last) begin
							mst_next = M_STOP; // stop after nack
						end else begin
							idx_next = idx_reg + 2'd1;
						end
					end
				end
				M_STOP: if (ph_reg == 5'd2) begin
					mst_next = M_IDLE;
					fin      = 1'b1;
				end
				default: mst_next = M_IDLE;
			endcase
		end
	end

	// pin levels per phase; sda bits from msb down
	always_comb begin
		scl_low_w = 1'b0;
		sda_low_w = 1'b0;
		case (mst_reg)
			M_START: begin
				scl_low_w = ph_reg == 5'd0;
				sda_low_w = ph_reg == 5'd2;
			end
			M_SEND: begin
				scl_low_w = ~ph_reg[0];
				sda_low_w = (bit_w < 4'd8) & ~tx_byte[3'(4'd7 - bit_w)];
			end
			M_RECV: begin
				scl_low_w = ~ph_reg[0];
				sda_low_w = (bit_w == 4'd8) & ~last; // ack all but last
			end
			M_STOP: begin
				scl_low_w = ph_reg == 5'd0;
				sda_low_w = ph_reg != 5'd2; // held low until released for the stop
			end
			default: ;
		endcase
	end

	// sda moves only under a low clock, or for start and stop
	wire start_stop = (mst_reg == M_START) | (mst_reg == M_STOP);
	wire sda_upd = scl_low_reg ? scl_low_w : (~scl_low_w & start_stop);

	// apb slave registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
			cmd_reg     <= 32'h0;
			wdata_reg   <= 32'h0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
			if (setup & ~pwrite) prdata_reg <= rd_mux;
			if (cmd_wr) cmd_reg <= pwdata;
			if (access & pwrite & sel_wd & ~busy_reg) wdata_reg <= pwdata;
		end
	end

	// status flags: a hardware set wins over a write-one clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busy_reg  <= 1'b0;
			nack_reg  <= 1'b0;
			done_reg  <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			busy_reg <= launch | (busy_reg & ~fin);
			nack_reg <= nack_set | (nack_reg & ~(st_wr & pwdata[`STATUS_NACK_BIT]));
			done_reg <= fin | (done_reg & ~(st_wr & pwdata[`STATUS_DONE_BIT]));
			if (launch) rdata_reg <= 32'h0;
			else if (recv_end) rdata_reg[{idx_reg, 3'b000} +: 8] <= sh_reg;
		end
	end

	// engine state, divider and pins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mst_reg      <= M_IDLE;
			kind_reg     <= K_SLAVE_W;
			ph_reg       <= 5'd0;
			idx_reg      <= 2'd0;
			rs_reg       <= 1'b0;
			sh_reg       <= 8'h00;
			div_reg      <= 16'h0;
			sda_sync_reg <= 2'b11;
			scl_low_reg  <= 1'b0;
			sda_low_reg  <= 1'b0;
			zero_reg     <= 1'b0;
		end else begin
			mst_reg      <= mst_next;
			kind_reg     <= kind_next;
			ph_reg       <= ph_next;
			idx_reg      <= idx_next;
			rs_reg       <= rs_next;
			sh_reg       <= sh_next;
			div_reg      <= (tick | ~busy_reg) ? 16'h0 : div_reg + 16'h1;
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			scl_low_reg  <= scl_low_w;
			if (sda_upd) sda_low_reg <= sda_low_w;
		end
	end

	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
	assign busy          = busy_reg;
	assign link.scl_o    = zero_reg;
	assign link.scl_oe   = scl_low_reg;
	assign link.sda_m_o  = zero_reg;
	assign link.sda_m_oe = sda_low_reg;
endmodule // cascade_serial_master

// *** hw/cascade_serial_slave.sv ***
// two-wire register slave with cascade pass-through
//
// How it works
// - sda changes only while scl is low
// - ignore everything until a start is seen
// - stop ends transfer, device back to standby
// - receiver pulls sda low on ninth clock
// - ack matching slave byte, all written bytes
// - read: eight bits, sample ack, continue or cease
// - master stops after the final nack
// - write: slave, register address, data, stop
// - data loads on fall after eighth bit
// - pointer increments after write ack, wraps at last
// - addressed read uses repeated start, read bit
// - pointer advances after eighth bit read out
// - current-address read uses retained pointer
// - lower answers 0101000, upper 0101001
// - lower forwards bus bits to cascade port
// - unaddressed device ignores until stop, still forwards
// - three config registers locked after reset
// - unlock bits 7, 6, 5 free registers 7, 6, 5
// - clearing an unlock bit relocks its register
// - bytes travel most significant bit first
// - master starts transfers and drives the clock
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "csr_defs.svh"
module cascade_serial_slave
	import csr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `LOWER_DEV_ADDR,
	parameter bit         IS_LOWER = 1'b1
)(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	link_if.dev             link,
	output logic      [7:0] discharge_config,
	output logic      [7:0] charge_config,
	output logic      [7:0] feature_config,
	output logic      [7:0] config_write_unlock,
	output logic            selected,
	output logic            cascade_clock_out,
	output logic            cascade_data_out_lower,
	input  wire logic       cascade_data_in_lower
);
	logic [1:0]  scl_sync_reg, sda_sync_reg, casc_sync_reg;
	logic        scl_d_reg, sda_d_reg;
	slv_state_t  state_reg, state_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [7:0]  rx_reg, rx_next;
	logic [7:0]  tx_reg, tx_next;
	logic [3:0]  ptr_reg, ptr_next;
	logic        oe_reg, oe_next;
	logic        rw_reg, rw_next;
	logic        ack_reg, ack_next;
	logic        wr_en;
	logic        sda_drv_reg, zero_reg, sel_reg;
	logic        casc_clk_reg, casc_dat_reg;
	logic [7:0]  mem_reg [0:`REG_COUNT-1];

	// registered line levels and their edges
	wire scl_s     = scl_sync_reg[1];
	wire sda_s     = sda_sync_reg[1];
	wire scl_rise  = scl_s & ~scl_d_reg;
	wire scl_fall  = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire byte_done = cnt_reg == 4'h8;

	// register access decode
	wire       in_range = ptr_reg <= `REG_LAST;
	wire [3:0] ptr_inc  = (ptr_reg >= `REG_LAST) ? 4'h0 : ptr_reg + 4'h1;
	wire [7:0] rd_byte  = in_range ? mem_reg[ptr_reg] : 8'h00;
	wire [7:0] unlock_w = mem_reg[`REG_WRITE_UNLOCK];
	wire addr_match = rx_reg[7:1] == DEV_ADDR;
	// locked until its unlock bit is set; clearing relocks
	wire locked =
		((ptr_reg == `REG_FEATURE_CONFIG) &
			~unlock_w[`UNLOCK_FEATURE_BIT]) |
		((ptr_reg == `REG_CHARGE_CONFIG) &
			~unlock_w[`UNLOCK_CHARGE_BIT]) |
		((ptr_reg == `REG_DISCHARGE_CONFIG) &
			~unlock_w[`UNLOCK_DISCHARGE_BIT]);
	wire wr_ok = wr_en & in_range & ~locked;

	// protocol engine; samples on rises, drives sda on falls only, so sda moves with scl low
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		rx_next    = rx_reg;
		tx_next    = tx_reg;
		ptr_next   = ptr_reg;
		oe_next    = oe_reg;
		rw_next    = rw_reg;
		ack_next   = ack_reg;
		wr_en      = 1'b0;
		if (stop_det) begin
			state_next = S_IDLE; // standby
			oe_next    = 1'b0;
		end else if (start_det && state_reg != S_IGNORE) begin
			state_next = S_SLAVE; // start or repeated start
			cnt_next   = 4'h0;
			oe_next    = 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				S_SLAVE, S_REG, S_WDAT: if (!byte_done) begin
					rx_next  = {rx_reg[6:0], sda_s}; // msb first
					cnt_next = cnt_reg + 4'h1;
				end
				S_TX: cnt_next = cnt_reg + 4'h1;
				S_TX_ACK: ack_next = ~sda_s;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				S_SLAVE: if (byte_done) begin
					if (addr_match) begin
						oe_next    = 1'b1;
						rw_next    = rx_reg[0];
						state_next = S_SLV_ACK;
					end else begin
						state_next = S_IGNORE;
					end
				end
				S_REG: if (byte_done) begin
					ptr_next   = rx_reg[3:0];
					oe_next    = 1'b1;
					state_next = S_REG_ACK;
				end
				S_WDAT: if (byte_done) begin
					wr_en      = 1'b1;
					oe_next    = 1'b1;
					state_next = S_WACK;
				end
				S_SLV_ACK: begin
					cnt_next = 4'h0;
					if (rw_reg) begin
						tx_next    = rd_byte; // retained pointer
						oe_next    = ~rd_byte[7];
						state_next = S_TX;
					end else begin
						oe_next    = 1'b0;
						state_next = S_REG;
					end
				end
				S_REG_ACK: begin
					oe_next    = 1'b0;
					cnt_next   = 4'h0;
					state_next = S_WDAT;
				end
				S_WACK: begin
					oe_next    = 1'b0;
					cnt_next   = 4'h0;
					ptr_next   = ptr_inc;
					state_next = S_WDAT;
				end
				S_TX: if (byte_done) begin
					oe_next    = 1'b0; // release for ack
					ptr_next   = ptr_inc;
					state_next = S_TX_ACK;
				end else begin
					tx_next = {tx_reg[6:0], 1'b0};
					oe_next = ~tx_reg[6];
				end
				S_TX_ACK: if (ack_reg) begin
					tx_next    = rd_byte; // next register
					oe_next    = ~rd_byte[7];
					cnt_next   = 4'h0;
					state_next = S_TX;
				end else begin
					oe_next    = 1'b0; // cease until stop
					state_next = S_IGNORE;
				end
				default: ;
			endcase
		end
	end

	// synchronisers and edge history
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_sync_reg  <= 2'b11;
			sda_sync_reg  <= 2'b11;
			casc_sync_reg <= 2'b11;
			scl_d_reg     <= 1'b1;
			sda_d_reg     <= 1'b1;
		end else begin
			scl_sync_reg  <= {scl_sync_reg[0], link.scl};
			sda_sync_reg  <= {sda_sync_reg[0], link.sda};
			casc_sync_reg <= {casc_sync_reg[0], cascade_data_in_lower};
			scl_d_reg     <= scl_s;
			sda_d_reg     <= sda_s;
		end
	end

	// engine state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 4'h0;
			rx_reg    <= 8'h00;
			tx_reg    <= 8'h00;
			ptr_reg   <= 4'h0;
			oe_reg    <= 1'b0;
			rw_reg    <= 1'b0;
			ack_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			rx_reg    <= rx_next;
			tx_reg    <= tx_next;
			ptr_reg   <= ptr_next;
			oe_reg    <= oe_next;
			rw_reg    <= rw_next;
			ack_reg   <= ack_next;
		end
	end

	// register file; config registers reset locked
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				mem_reg[i] <= `REG_RESET_VALUE;
			end
		end else if (wr_ok) begin
			mem_reg[ptr_reg] <= rx_reg;
		end
	end

	// pins; the lower end also relays the upper end's pull-down
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sda_drv_reg  <= 1'b0;
			zero_reg     <= 1'b0;
			sel_reg      <= 1'b0;
			casc_clk_reg <= 1'b1;
			casc_dat_reg <= 1'b1;
		end else begin
			sda_drv_reg  <= oe_reg | (IS_LOWER & ~casc_sync_reg[1]);
			zero_reg     <= 1'b0;
			sel_reg      <= (state_reg != S_IDLE) &&
				(state_reg != S_IGNORE) && (state_reg != S_SLAVE);
			// forwarded even while ignoring
			casc_clk_reg <= IS_LOWER ? scl_s : 1'b1;
			casc_dat_reg <= IS_LOWER ? sda_s : 1'b1;
		end
	end

	assign link.sda_s_o            = zero_reg;
	assign link.sda_s_oe           = sda_drv_reg;
	assign discharge_config        = mem_reg[`REG_DISCHARGE_CONFIG];
	assign charge_config           = mem_reg[`REG_CHARGE_CONFIG];
	assign feature_config          = mem_reg[`REG_FEATURE_CONFIG];
	assign config_write_unlock     = mem_reg[`REG_WRITE_UNLOCK];
	assign selected                = sel_reg;
	assign cascade_clock_out       = casc_clk_reg;
	assign cascade_data_out_lower  = casc_dat_reg;
endmodule // cascade_serial_slave

// *** pkg/csr_defs.svh ***
// constants shared by the serial register slave and its bus controller
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH

// slave addresses of the two cascaded devices
`define LOWER_DEV_ADDR        7'h28
`define UPPER_DEV_ADDR        7'h29

// register file layout
`define REG_COUNT             11
`define REG_LAST              4'ha
`define REG_DISCHARGE_CONFIG  4'h5
`define REG_CHARGE_CONFIG     4'h6
`define REG_FEATURE_CONFIG    4'h7
`define REG_WRITE_UNLOCK      4'h8
`define REG_RESET_VALUE       8'h00

// unlock bits in the write-unlock register
`define UNLOCK_FEATURE_BIT    7
`define UNLOCK_CHARGE_BIT     6
`define UNLOCK_DISCHARGE_BIT  5

// serial clock timing of the controller
`define CLK_PERIOD_NS         10
`define SCL_HALF_NS           5000
`define SCL_HALF_CYC ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// controller register offsets on apb
`define APB_CMD_OFS           12'h000
`define APB_WDATA_OFS         12'h004
`define APB_RDATA_OFS         12'h008
`define APB_STATUS_OFS        12'h00c

// command register fields
`define CMD_GO_BIT            0
`define CMD_READ_BIT          1
`define CMD_CUR_BIT           2
`define CMD_LEN_LSB           4
`define CMD_DEV_LSB           8
`define CMD_REG_LSB           16

// status register fields
`define STATUS_BUSY_BIT       0
`define STATUS_NACK_BIT       1
`define STATUS_DONE_BIT       2

`endif

// *** pkg/csr_pkg.sv ***
// types shared by the serial register slave and its bus controller
package csr_pkg;

	typedef enum logic [3:0] {
		S_IDLE    = 4'b0000,
		S_SLAVE   = 4'b0001,
		S_SLV_ACK = 4'b0011,
		S_REG     = 4'b0010,
		S_REG_ACK = 4'b0110,
		S_WDAT    = 4'b0111,
		S_WACK    = 4'b0101,
		S_TX      = 4'b0100,
		S_TX_ACK  = 4'b1100,
		S_IGNORE  = 4'b1101
	} slv_state_t;

	typedef enum logic [2:0] {
		M_IDLE  = 3'b000,
		M_START = 3'b001,
		M_SEND  = 3'b011,
		M_RECV  = 3'b010,
		M_STOP  = 3'b110
	} mst_state_t;

	typedef enum logic [1:0] {
		K_SLAVE_W = 2'b00,
		K_REG     = 2'b01,
		K_DATA    = 2'b11,
		K_SLAVE_R = 2'b10
	} byte_kind_t;

endpackage

// *** pkg/link_if.sv ***
// two-wire link between controller and slave, open-drain resolution
`timescale 1ns/1ps
interface link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// a line is low while any enabled driver drives low, else pulled up
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_s_oe & ~sda_s_o);

	modport ctrl (output scl_o, output scl_oe, output sda_m_o,
		output sda_m_oe, input scl, input sda);
	modport dev (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

// *** tb/cascaded_serial_register_slave_assertions.sv ***
// link checker for the controller to lower device wires
`timescale 1ns/1ps
module cascaded_serial_register_slave_assertions (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// slave data moves only in the low phase of the clock; master data never moves on a clock edge
	chk_slave_sda_low: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("slave data moved while clock high");
	chk_master_no_race: assert property ($changed(scl_oe) |-> $stable(sda_m_oe))
		else $error("master data moved on a clock edge");
	// a start keeps the clock high long enough to be seen
	chk_start_hold: assert property (scl && $fell(sda) |-> scl[*3])
		else $error("start too short");
	// after a stop the slave stays off the line
	chk_stop_quiet: assert property (scl && $rose(sda) |-> !sda_s_oe[*8])
		else $error("slave drove after stop");
	chk_ack_in_low: assert property ($rose(sda_s_oe) |-> !scl[*3])
		else $error("slave pull-down late in low phase");
	// master and slave never drive data together while the clock is high
	chk_no_contend: assert property (scl |-> !(sda_s_oe && sda_m_oe))
		else $error("both ends drive data while clock high");
	// lag after the clock fell: own answer 4 cycles, relayed upper one 10
	chk_slave_lag: assert property ($changed(sda_s_oe)
		|-> !$past(scl, 2) && $past(scl, 11))
		else $error("slave answer lag out of range");
	chk_scl_half: assert property ($rose(scl_oe) |-> scl_oe[*8])
		else $error("clock low phase too short");

	cov_ack: cover property ($rose(sda_s_oe));
	cov_start: cover property (scl && $fell(sda));
	cov_stop: cover property (scl && $rose(sda));
endmodule // cascaded_serial_register_slave_assertions

// *** tb/test_cascaded_serial_register_slave.sv ***
// bench: apb controller talking to a lower and upper device cascade
`timescale 1ns/1ps
`include "csr_defs.svh"
module test_cascaded_serial_register_slave;
	import csr_pkg::*;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic        busy, last_err, ps, pd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, st, r;
	logic [7:0]  lo_d, lo_c, lo_f, lo_u, hi_d, hi_c, hi_f, hi_u;
	logic        lo_sel, hi_sel, lo_clk, lo_dat, hi_clk, hi_dat;
	logic [8:0]  wbits;
	int          wcnt = 9, mismatches = 0, checks = 0, cyc = 0;

	link_if link();
	link_if link_up();
	// upper link is driven from the lower device's relayed wires
	assign link_up.scl_oe = ~lo_clk;
	assign link_up.scl_o = 1'b0;
	assign link_up.sda_m_oe = ~lo_dat;
	assign link_up.sda_m_o = 1'b0;

	cascade_serial_master #(.HALF_CYC(20)) u_cascade_serial_master (
		.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.busy(busy), .link(link));
	// lower device runs on the parameter defaults
	cascade_serial_slave u_cascade_serial_slave (.clk_sys(clk_sys),
		.rst(rst), .link(link),
		.discharge_config(lo_d), .charge_config(lo_c),
		.feature_config(lo_f), .config_write_unlock(lo_u),
		.selected(lo_sel), .cascade_clock_out(lo_clk),
		.cascade_data_out_lower(lo_dat),
		.cascade_data_in_lower(~link_up.sda_s_oe));
	cascade_serial_slave #(.DEV_ADDR(7'h29), .IS_LOWER(1'b0))
		u_cascade_serial_slave_hi (.clk_sys(clk_sys), .rst(rst),
		.link(link_up), .discharge_config(hi_d), .charge_config(hi_c),
		.feature_config(hi_f), .config_write_unlock(hi_u),
		.selected(hi_sel), .cascade_clock_out(hi_clk),
		.cascade_data_out_lower(hi_dat), .cascade_data_in_lower(1'b1));
	cascaded_serial_register_slave_assertions u_chk (.clk_sys(clk_sys),
		.rst(rst), .scl(link.scl), .sda(link.sda), .scl_oe(link.scl_oe),
		.sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// wire monitor: first nine bits after a start, sampled on clock rise
	always @(posedge clk_sys) begin
		ps <= link.scl;
		pd <= link.sda;
		if (ps && link.scl && pd && !link.sda)
			wcnt <= 0;
		else if (!ps && link.scl && wcnt < 9) begin
			wcnt <= wcnt + 1;
			wbits <= {wbits[7:0], link.sda};
		end
	end

	// hang guard, well above the longest expected run
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer; answer taken at the rising edge with pready high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		last_err = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	function automatic logic [31:0] cmd(input logic [6:0] d,
		input logic [7:0] g, input logic [1:0] l, input logic rd,
		input logic cu);
		return {8'h00, g, 1'b0, d, 2'b00, l, 1'b0, cu, rd, 1'b1};
	endfunction

	// launch a transfer, wait for busy to drop, clear the sticky flags
	// a transfer that never ends is caught by the hang guard
	task automatic run(input logic [31:0] c, input logic [31:0] wd);
		apb(1'b1, `APB_WDATA_OFS, wd, r);
		apb(1'b1, `APB_CMD_OFS, c, r);
		do begin
			apb(1'b0, `APB_STATUS_OFS, 32'h0, st);
		end while (st[0] !== 1'b0);
		cmp({busy, lo_sel, hi_sel}, 32'h0);
		apb(1'b1, `APB_STATUS_OFS, 32'h6, r);
		apb(1'b0, `APB_RDATA_OFS, 32'h0, r);
	endtask

	task automatic t_reset();
		cmp({lo_d, lo_c, lo_f, lo_u}, 32'h0);
		cmp({link.scl, link.sda, lo_sel}, 32'h6);
		apb(1'b0, 12'h010, 32'h0, r);
		cmp(last_err, 1'b1);
		cmp(r, 32'h0);
	endtask

	task automatic t_lock();
		run(cmd(7'h28, 8'h05, 2'd0, 1'b0, 1'b0), 32'ha5);
		cmp(st[1], 1'b0);
		cmp(lo_d, 8'h00);
		cmp(wbits, {7'h28, 2'b00});
	endtask

	task automatic t_unlock();
		run(cmd(7'h28, 8'h08, 2'd0, 1'b0, 1'b0), 32'he0);
		run(cmd(7'h28, 8'h05, 2'd2, 1'b0, 1'b0), 32'hc3b2a1);
		cmp({lo_d, lo_c, lo_f, lo_u}, 32'ha1b2c3e0);
	endtask

	task automatic t_relock();
		run(cmd(7'h28, 8'h08, 2'd0, 1'b0, 1'b0), 32'h40);
		run(cmd(7'h28, 8'h05, 2'd2, 1'b0, 1'b0), 32'h665544);
		cmp({lo_d, lo_c, lo_f, lo_u}, 32'ha155c340);
	endtask

	// writes across the last register, then reads back both ways
	task automatic t_wrap();
		run(cmd(7'h28, 8'h0a, 2'd1, 1'b0, 1'b0), 32'h2211);
		run(cmd(7'h28, 8'h0a, 2'd1, 1'b1, 1'b0), 32'h0);
		cmp(r, 32'h2211);
		cmp(wbits, {7'h28, 2'b10});
		run(cmd(7'h28, 8'h0a, 2'd0, 1'b1, 1'b0), 32'h0);
		run(cmd(7'h28, 8'h00, 2'd0, 1'b1, 1'b1), 32'h0);
		cmp(r, 32'h22);
	endtask

	task automatic t_upper();
		run(cmd(7'h29, 8'h08, 2'd0, 1'b0, 1'b0), 32'h80);
		run(cmd(7'h29, 8'h07, 2'd0, 1'b0, 1'b0), 32'h3c);
		cmp({hi_f, hi_u, lo_f, lo_u}, 32'h3c80c340);
		cmp(wbits, {7'h29, 2'b00});
		run(cmd(7'h29, 8'h07, 2'd0, 1'b1, 1'b0), 32'h0);
		cmp(r, 32'h3c);
	endtask

	task automatic t_badaddr();
		run(cmd(7'h2a, 8'h08, 2'd0, 1'b0, 1'b0), 32'h00);
		cmp(st[1], 1'b1);
		cmp(wbits, {7'h2a, 2'b01});
		cmp({lo_u, hi_u}, 16'h4080);
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_lock();
		t_unlock();
		t_relock();
		t_wrap();
		t_upper();
		t_badaddr();
		final_report();
	end
endmodule // test_cascaded_serial_register_slave
